// file: design/jtap_pkg.sv
/*
 * Package for the test access port block: opcodes, register lengths,
 * identification fields, TAP state encoding and the pin-group structs.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package jtap_pkg;

    // Instruction register length
    localparam int IR_LEN = 10;
    // User code register length
    localparam int USERCODE_LEN = 32;
    // Identification code length
    localparam int IDCODE_LEN = 32;
    // Boundary-scan length choices, one per device size
    localparam int BSR_LEN_SMALL = 1317;
    localparam int BSR_LEN_MID   = 2157;
    localparam int BSR_LEN_LARGE = 2637;
    // Pin groups covered by the reduced boundary model
    localparam int NUM_PINS = 8;
    // PLL reconfiguration bits spliced into the chain before configuration
    localparam int PLL_BITS = 16;
    // I/O standard bits held for each pin
    localparam int IOSTD_BITS = 2;

    // Identification fields; values are arbitrary
    localparam logic [3:0]  ID_VERSION  = 4'h1;
    localparam logic [15:0] ID_PART     = 16'h1234;
    localparam logic [10:0] ID_MAKER    = 11'h2A5;
    localparam logic        ID_LSB      = 1'b1;

    // Opcodes
    localparam logic [9:0] OP_EXTEST    = 10'h000;
    localparam logic [9:0] OP_SAMPLE    = 10'h005;
    localparam logic [9:0] OP_IDCODE    = 10'h006;
    localparam logic [9:0] OP_USERCODE  = 10'h007;
    localparam logic [9:0] OP_CLAMP     = 10'h00A;
    localparam logic [9:0] OP_HIGHZ     = 10'h00B;
    localparam logic [9:0] OP_PULSE_RC  = 10'h001;
    localparam logic [9:0] OP_CONFIG_IO = 10'h00D;
    localparam logic [9:0] OP_ICR_LOAD  = 10'h002;
    localparam logic [9:0] OP_LA_ACCESS = 10'h00E;
    localparam logic [9:0] OP_BYPASS    = 10'h3FF;
    // Value captured into the instruction register
    localparam logic [9:0] IR_CAPTURE   = 10'h001;
    // Reset values
    localparam logic [31:0] USERCODE_RST = 32'hFFFF_FFFF;

    // TAP controller states
    typedef enum logic [3:0] {
        TS_RESET   = 4'h0, TS_IDLE    = 4'h1, TS_DR_SEL  = 4'h2, TS_DR_CAP  = 4'h3,
        TS_DR_SH   = 4'h4, TS_DR_EX1  = 4'h5, TS_DR_PAU  = 4'h6, TS_DR_EX2  = 4'h7,
        TS_DR_UPD  = 4'h8, TS_IR_SEL  = 4'h9, TS_IR_CAP  = 4'hA, TS_IR_SH   = 4'hB,
        TS_IR_EX1  = 4'hC, TS_IR_PAU  = 4'hD, TS_IR_EX2  = 4'hE, TS_IR_UPD  = 4'hF
    } jtap_state_type;

    // Serial test port pins
    typedef struct packed {
        logic tms;
        logic tdi;
    } jtap_port_in_type;

    // User pins: core side and pad side
    typedef struct packed {
        logic [NUM_PINS-1:0] core_out;
        logic [NUM_PINS-1:0] core_oe;
        logic [NUM_PINS-1:0] pad_in;
        logic [NUM_PINS-1:0] keeper_en;
    } jtap_pins_in_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] pad_out;
        logic [NUM_PINS-1:0] pad_oe;
        logic [NUM_PINS-1:0] pull_en;
        logic [NUM_PINS-1:0] core_in;
    } jtap_pins_out_type;

endpackage

// file: design/jtap_tap.sv
/*
 * Test access port with a 10-bit instruction register, bypass, user code,
 * identification, boundary-scan, I/O-standard and PLL chains, plus the
 * reconfiguration and analyser hooks. TAP logic runs on i_tck; status
 * from the device core crosses in through two flops, events cross out by
 * toggle. Assumes the core supplies configuration status on i_ref_clk.
 */
`timescale 1ns/1ps

module jtap_tap #(
    parameter int BSR_LEN = jtap_pkg::BSR_LEN_SMALL
) (
    // Core clock and reset
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_nrst,
    // Test port
    input  wire logic                         i_tck,
    input  wire logic                         i_ntrst,
    input  wire jtap_pkg::jtap_port_in_type   i_port,
    output logic                              o_tdo,
    output logic                              o_tdo_oe,
    // Device status from core
    input  wire logic                         i_power_good,
    input  wire logic                         i_configuring,
    input  wire logic                         i_configured,
    input  wire logic [31:0]                  i_usercode,
    // User pins
    input  wire jtap_pkg::jtap_pins_in_type   i_pins,
    output jtap_pkg::jtap_pins_out_type       o_pins,
    // I/O standards and PLL settings
    output logic [jtap_pkg::NUM_PINS*jtap_pkg::IOSTD_BITS-1:0] o_io_std,
    output logic [jtap_pkg::PLL_BITS-1:0]     o_pll_cfg,
    // Configuration hooks in core domain
    output logic                              o_reconfig_pulse,
    output logic                              o_config_abort,
    output logic                              o_cfg_data_valid,
    output logic                              o_cfg_data,
    // Analyser hook in TCK domain
    output logic                              o_la_select,
    output logic                              o_la_shift,
    output logic                              o_la_tdi,
    input  wire logic                         i_la_tdo
);
    import jtap_pkg::*;

    localparam int IOS_LEN = NUM_PINS * IOSTD_BITS;

    ////////////////////////////////////////////////////////////////////////
    // TCK domain: status synchronisers
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       pwr_ok;
    logic       cfg_busy;
    logic       cfg_done;

    // Two flops for each core status level
    always_ff @(posedge i_tck) begin
        sync1 <= {i_power_good, i_configuring, i_configured};
        sync2 <= sync1;
    end
    assign pwr_ok   = sync2[2];
    assign cfg_busy = sync2[1];
    assign cfg_done = sync2[0];

    ////////////////////////////////////////////////////////////////////////
    // TAP controller
    jtap_state_type state;
    jtap_state_type next_state;
    logic           tms;
    logic           tdi;

    assign tms = i_port.tms;
    assign tdi = i_port.tdi;

    // Standard sixteen-state walk on TMS
    always_comb begin
        case (state)
            TS_RESET:  next_state = tms ? TS_RESET  : TS_IDLE;
            TS_IDLE:   next_state = tms ? TS_DR_SEL : TS_IDLE;
            TS_DR_SEL: next_state = tms ? TS_IR_SEL : TS_DR_CAP;
            TS_DR_CAP: next_state = tms ? TS_DR_EX1 : TS_DR_SH;
            TS_DR_SH:  next_state = tms ? TS_DR_EX1 : TS_DR_SH;
            TS_DR_EX1: next_state = tms ? TS_DR_UPD : TS_DR_PAU;
            TS_DR_PAU: next_state = tms ? TS_DR_EX2 : TS_DR_PAU;
            TS_DR_EX2: next_state = tms ? TS_DR_UPD : TS_DR_SH;
            TS_DR_UPD: next_state = tms ? TS_DR_SEL : TS_IDLE;
            TS_IR_SEL: next_state = tms ? TS_RESET  : TS_IR_CAP;
            TS_IR_CAP: next_state = tms ? TS_IR_EX1 : TS_IR_SH;
            TS_IR_SH:  next_state = tms ? TS_IR_EX1 : TS_IR_SH;
            TS_IR_EX1: next_state = tms ? TS_IR_UPD : TS_IR_PAU;
            TS_IR_PAU: next_state = tms ? TS_IR_EX2 : TS_IR_PAU;
            TS_IR_EX2: next_state = tms ? TS_IR_UPD : TS_IR_SH;
            TS_IR_UPD: next_state = tms ? TS_DR_SEL : TS_IDLE;
            default:   next_state = TS_RESET;
        endcase
    end

    // State register; test reset forces Test-Logic-Reset
    always_ff @(posedge i_tck) begin
        if (!i_ntrst || !pwr_ok) begin
            state <= TS_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction register
    logic [IR_LEN-1:0] ir_shift;
    logic [IR_LEN-1:0] ir;

    // Ten-bit shift stage, loaded to active on update
    always_ff @(posedge i_tck) begin
        if (state == TS_RESET) begin
            ir_shift <= OP_IDCODE;
            ir       <= OP_IDCODE;
        end else if (state == TS_IR_CAP) begin
            ir_shift <= IR_CAPTURE;
        end else if (state == TS_IR_SH) begin
            ir_shift <= {tdi, ir_shift[IR_LEN-1:1]};
        end else if (state == TS_IR_UPD) begin
            ir <= ir_shift;
        end
    end

    // Instruction decode
    logic is_extest, is_sample, is_id, is_user, is_clamp, is_highz;
    logic is_pulse, is_cfgio, is_icr, is_la, sel_bsr, sel_bypass;
    assign is_extest = (ir == OP_EXTEST);
    assign is_sample = (ir == OP_SAMPLE);
    assign is_id     = (ir == OP_IDCODE);
    assign is_user   = (ir == OP_USERCODE);
    assign is_clamp  = (ir == OP_CLAMP);
    assign is_highz  = (ir == OP_HIGHZ);
    assign is_pulse  = (ir == OP_PULSE_RC);
    assign is_cfgio  = (ir == OP_CONFIG_IO);
    assign is_icr    = (ir == OP_ICR_LOAD);
    assign is_la     = (ir == OP_LA_ACCESS);
    assign sel_bsr   = is_extest | is_sample;
    // Bypass for its own opcode, HIGHZ, CLAMP and anything unknown
    assign sel_bypass = !(sel_bsr | is_id | is_user | is_cfgio | is_icr
                          | is_la | is_pulse);

    logic dr_cap, dr_sh, dr_upd;
    assign dr_cap = (state == TS_DR_CAP);
    assign dr_sh  = (state == TS_DR_SH);
    assign dr_upd = (state == TS_DR_UPD);

    ////////////////////////////////////////////////////////////////////////
    // Data registers
    logic                  bypass_bit;
    logic [31:0]           id_shift;
    logic [31:0]           user_shift;
    logic [BSR_LEN-1:0]    bsr_shift;
    logic [BSR_LEN-1:0]    bsr_upd;
    logic [IOS_LEN-1:0]    ios_shift;
    logic [PLL_BITS-1:0]   pll_shift;
    logic                  pll_in_chain;

    // Bypass cell captures zero
    always_ff @(posedge i_tck) begin
        if (dr_cap) begin
            bypass_bit <= 1'b0;
        end else if (dr_sh) begin
            bypass_bit <= tdi;
        end
    end

    // Identification and user code chains
    always_ff @(posedge i_tck) begin
        if (dr_cap) begin
            id_shift   <= {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
            user_shift <= cfg_done ? i_usercode : USERCODE_RST;
        end else if (dr_sh) begin
            id_shift   <= {tdi, id_shift[31:1]};
            user_shift <= {tdi, user_shift[31:1]};
        end
    end

    // Boundary cells: pads captured, then shifted, then updated
    // Cell layout per pin i: input at i, output at N+i, enable at 2N+i
    always_ff @(posedge i_tck) begin
        if (state == TS_RESET) begin
            bsr_upd <= '0;
        end else if (dr_cap && sel_bsr) begin
            bsr_shift                          <= '0;             // Unused cells read zero
            bsr_shift[NUM_PINS-1:0]            <= i_pins.pad_in;
            bsr_shift[2*NUM_PINS-1:NUM_PINS]   <= i_pins.core_out;
            bsr_shift[3*NUM_PINS-1:2*NUM_PINS] <= i_pins.core_oe;
        end else if (dr_sh && sel_bsr) begin
            bsr_shift <= {tdi, bsr_shift[BSR_LEN-1:1]};
        end else if (dr_upd && sel_bsr) begin
            bsr_upd <= bsr_shift;
        end
    end

    // I/O standard chain with PLL bits spliced in before configuration
    always_ff @(posedge i_tck) begin
        if (!pwr_ok) begin
            o_io_std  <= '0;
            o_pll_cfg <= '0;
        end else if (dr_sh && is_cfgio) begin
            ios_shift <= {tdi, ios_shift[IOS_LEN-1:1]};
            pll_shift <= {ios_shift[0], pll_shift[PLL_BITS-1:1]};
        end else if (dr_upd && is_cfgio) begin
            o_io_std <= ios_shift;
            if (pll_in_chain) begin
                o_pll_cfg <= pll_shift;
            end
        end
    end
    assign pll_in_chain = !cfg_done;

    ////////////////////////////////////////////////////////////////////////
    // TDO selection, changed on the falling edge
    logic tdo_mux;
    always_comb begin
        if (state == TS_IR_SH) begin
            tdo_mux = ir_shift[0];
        end else if (sel_bsr) begin
            tdo_mux = bsr_shift[0];
        end else if (is_id) begin
            tdo_mux = id_shift[0];
        end else if (is_user) begin
            tdo_mux = user_shift[0];
        end else if (is_cfgio) begin
            tdo_mux = pll_in_chain ? pll_shift[0] : ios_shift[0];
        end else if (is_la) begin
            tdo_mux = i_la_tdo;
        end else begin
            tdo_mux = bypass_bit;
        end
    end

    always_ff @(negedge i_tck) begin
        o_tdo    <= tdo_mux;
        o_tdo_oe <= pwr_ok && (state == TS_IR_SH || state == TS_DR_SH);
    end

    // Analyser hook select, shift and serial data in TCK domain
    assign o_la_select = is_la;
    assign o_la_shift  = is_la && dr_sh;
    assign o_la_tdi    = tdi;

    ////////////////////////////////////////////////////////////////////////
    // Pin control
    logic        scan_drive;
    logic [NUM_PINS-1:0] pad_oe;
    // EXTEST and CLAMP drive from update cells, HIGHZ floats all
    assign scan_drive = is_extest | is_clamp;
    always_comb begin
        if (!pwr_ok || !cfg_done && !scan_drive) begin
            pad_oe = '0;
        end else if (is_highz) begin
            pad_oe = '0;
        end else if (scan_drive) begin
            pad_oe = bsr_upd[3*NUM_PINS-1:2*NUM_PINS];
        end else begin
            pad_oe = i_pins.core_oe;
        end
    end
    assign o_pins.pad_oe  = pad_oe;
    assign o_pins.pad_out = scan_drive ? bsr_upd[2*NUM_PINS-1:NUM_PINS]
                                       : i_pins.core_out;
    // Keepers stay active when scan floats a pin; pull-ups only while unconfigured
    assign o_pins.pull_en = i_pins.keeper_en | (~pad_oe & {NUM_PINS{!cfg_done}});
    // EXTEST isolates the core from pad inputs
    assign o_pins.core_in = is_extest ? bsr_upd[NUM_PINS-1:0] : i_pins.pad_in;

    ////////////////////////////////////////////////////////////////////////
    // Events to core: pulse and abort toggle on IR update, data toggles on each ICR shift bit
    logic pulse_tgl, abort_tgl, data_tgl, data_bit;
    always_ff @(posedge i_tck) begin
        if (!pwr_ok) begin
            pulse_tgl <= 1'b0;
            abort_tgl <= 1'b0;
            data_tgl  <= 1'b0;
            data_bit  <= 1'b0;
        end else begin
            if (state == TS_IR_UPD && ir_shift == OP_PULSE_RC) begin
                pulse_tgl <= ~pulse_tgl;
            end
            if (state == TS_IR_UPD && ir_shift == OP_CONFIG_IO && cfg_busy) begin
                abort_tgl <= ~abort_tgl;
            end
            if (dr_sh && is_icr) begin
                data_tgl <= ~data_tgl;
                data_bit <= tdi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: receive toggles
    logic [2:0] ev_s1, ev_s2, ev_s3;
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            ev_s1  <= '0;
            ev_s2  <= '0;
            ev_s3  <= '0;
        end else begin
            ev_s1  <= {pulse_tgl, abort_tgl, data_tgl};
            ev_s2  <= ev_s1;
            ev_s3  <= ev_s2;
        end
    end

    // One-cycle pulses in core domain; physical pin untouched
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_reconfig_pulse <= 1'b0;
            o_config_abort   <= 1'b0;
            o_cfg_data_valid <= 1'b0;
            o_cfg_data       <= 1'b0;
        end else begin
            o_reconfig_pulse <= ev_s2[2] ^ ev_s3[2];
            o_config_abort   <= ev_s2[1] ^ ev_s3[1];
            o_cfg_data_valid <= ev_s2[0] ^ ev_s3[0];
            // Data bit has stood still since its toggle, so it is safe to take here
            if (ev_s2[0] ^ ev_s3[0]) begin
                o_cfg_data <= data_bit;
            end
        end
    end

    // Pin control outside configuration is the controller's duty

endmodule

// file: sim/jtap_tap_props.sv
/*
 * Checker for the test port block: core pulses, quiet pins, TAP reset,
 * keeper priority, frozen PLL bits, analyser data path.
 * Assumes a bind onto jtap_tap; sees only its ports.
 */
`timescale 1ns/1ps

module jtap_tap_props (
    // Clocks and resets
    input wire logic                        i_ref_clk,
    input wire logic                        i_nrst,
    input wire logic                        i_tck,
    input wire logic                        i_ntrst,
    // Port and status
    input wire jtap_pkg::jtap_port_in_type  i_port,
    input wire logic                        o_tdo_oe,
    input wire logic                        i_power_good,
    input wire logic                        i_configured,
    // Pins and hooks
    input wire jtap_pkg::jtap_pins_in_type  i_pins,
    input wire jtap_pkg::jtap_pins_out_type o_pins,
    input wire logic [jtap_pkg::PLL_BITS-1:0] o_pll_cfg,
    input wire logic                        o_reconfig_pulse,
    input wire logic                        o_config_abort,
    input wire logic                        o_cfg_data_valid,
    input wire logic                        o_la_select,
    input wire logic                        o_la_tdi
);
    import jtap_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Core events are single-cycle pulses
    recfg_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_reconfig_pulse |=> !o_reconfig_pulse) else $error("reconfig pulse too long");
    abort_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_config_abort |=> !o_config_abort) else $error("abort pulse too long");
    cfg_strobe_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_cfg_data_valid |=> !o_cfg_data_valid) else $error("data strobe too long");
    // Keepers win over scan-driven float
    keeper_wins_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (o_pins.pull_en & i_pins.keeper_en) == i_pins.keeper_en) else $error("keeper lost");
    ////////////////////////////////////////////////////////////////////////
    // Nothing driven while power is not good
    quiet_power_a: assert property (@(posedge i_tck) disable iff (!i_ntrst)
        (!i_power_good && !i_configured) [*6] |-> o_pins.pad_oe == '0 && !o_tdo_oe)
        else $error("output driven during power-up");
    // Every undriven pin is pulled while the device is unconfigured
    float_pull_a: assert property (@(posedge i_tck) disable iff (!i_ntrst)
        (!i_configured) [*4] |-> (o_pins.pull_en | o_pins.pad_oe) == '1)
        else $error("floating pin without pull-up");
    tms_reset_a: assert property (@(posedge i_tck) disable iff (!i_ntrst)
        i_port.tms [*7] |-> !o_tdo_oe && !o_la_select) else $error("TMS reset missed");
    pll_frozen_a: assert property (@(posedge i_tck) disable iff (!i_ntrst)
        (i_configured && i_power_good) [*4] |-> $stable(o_pll_cfg))
        else $error("PLL bits changed after configuration");
    la_path_a: assert property (@(posedge i_tck) disable iff (!i_ntrst)
        o_la_select |-> o_la_tdi == i_port.tdi) else $error("analyser input not TDI");

    // Main scenarios reached
    cover property (@(posedge i_ref_clk) o_reconfig_pulse);
    cover property (@(posedge i_ref_clk) o_config_abort);
    cover property (@(posedge i_ref_clk) o_cfg_data_valid);
    cover property (@(posedge i_tck) o_la_select);
endmodule

bind jtap_tap jtap_tap_props jtap_tap_props_i (.i_ref_clk, .i_nrst, .i_tck, .i_ntrst,
    .i_port, .o_tdo_oe, .i_power_good, .i_configured, .i_pins, .o_pins, .o_pll_cfg,
    .o_reconfig_pulse, .o_config_abort, .o_cfg_data_valid, .o_la_select, .o_la_tdi);

// file: sim/jtap_ctrl_model.sv
/*
 * Board-side test controller: clock only inside frames, LSB first.
 * Assumes the device samples on the rising and drives on the falling edge.
 */
`timescale 1ns/1ps

module jtap_ctrl_model (
    // Toward the device
    output logic     o_tck,
    output logic     o_ntrst,
    output logic     o_tms,
    output logic     o_tdi,
    // Serial answer
    input wire logic i_tdo
);
    // Idle levels; clock stands low between frames
    initial begin
        o_tck = 1'b0;
        o_ntrst = 1'b1;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end

    // One 32 ns clock; TDO taken at the rising edge
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        o_tms = tms_v;
        o_tdi = tdi_v;
        #16;
        o_tck = 1'b1;
        tdo_v = i_tdo;
        #16;
        o_tck = 1'b0;
    endtask

    // Walk to Test-Logic-Reset, optionally with the reset pin, then idle
    task automatic reset_tap(input logic use_trst);
        logic t;
        o_ntrst = !use_trst;
        repeat (8) step(1'b1, 1'b0, t);
        o_ntrst = 1'b1;
        step(1'b0, 1'b0, t);
    endtask

    // Capture, shift n bits, update, back to idle
    task automatic shift(input logic ir, input int n, input logic [63:0] din,
                         output logic [63:0] dout);
        logic t;
        dout = '0;
        step(1'b1, 1'b0, t);
        if (ir) begin
            step(1'b1, 1'b0, t);
        end
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i % 64], t);
            if (i < 64) begin
                dout[i] = t;
            end
        end
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        o_tdi = ~o_tdi; // Released line shows no stale bit
    endtask
endmodule

// file: sim/testbench.sv
/*
 * Self-checking bench for the test port block.
 * Assumes jtap_pkg, jtap_tap, the controller model and the checker.
 */
`timescale 1ns/1ps

module testbench;
    import jtap_pkg::*;

    localparam int BSR = BSR_LEN_SMALL; // Smallest device size
    logic i_ref_clk = 1'b0;
    logic i_nrst, i_tck, i_ntrst, tms, tdi, o_tdo, o_tdo_oe, i_la_tdo;
    logic i_power_good, i_configuring, i_configured, o_la_select, o_la_shift, o_la_tdi;
    logic o_reconfig_pulse, o_config_abort, o_cfg_data_valid, o_cfg_data;
    jtap_port_in_type  i_port;
    jtap_pins_in_type  i_pins;
    jtap_pins_out_type o_pins;
    logic [31:0] i_usercode;
    logic [NUM_PINS*IOSTD_BITS-1:0] o_io_std;
    logic [PLL_BITS-1:0] o_pll_cfg;
    logic [63:0] d, din;
    logic [7:0] pat, cfg_bits;
    logic [15:0] pll_keep;
    logic [9:0] ops[4];
    logic [31:0] seed = 32'had1e_b2bf;
    int num_errors = 0, checks = 0, cycles = 0, n_pulse = 0, n_abort = 0, n_valid = 0;

    jtap_tap #(.BSR_LEN(BSR)) jtap_tap_i (.i_ref_clk, .i_nrst, .i_tck, .i_ntrst, .i_port,
        .o_tdo, .o_tdo_oe, .i_power_good, .i_configuring, .i_configured, .i_usercode,
        .i_pins, .o_pins, .o_io_std, .o_pll_cfg, .o_reconfig_pulse, .o_config_abort,
        .o_cfg_data_valid, .o_cfg_data, .o_la_select, .o_la_shift, .o_la_tdi, .i_la_tdo);
    jtap_ctrl_model jtap_ctrl_model_i (.o_tck(i_tck), .o_ntrst(i_ntrst), .o_tms(tms),
        .o_tdi(tdi), .i_tdo(o_tdo_oe ? o_tdo : 1'b1)); // TDO idles at its pull-up
    assign i_port = {tms, tdi};

    // Reference clock
    always #2.5 i_ref_clk = ~i_ref_clk;

    // Counts core events, gathers data bits, cuts a hang short
    always @(posedge i_ref_clk) begin
        if (o_reconfig_pulse === 1'b1) n_pulse++;
        if (o_config_abort === 1'b1) n_abort++;
        if (o_cfg_data_valid === 1'b1) begin
            n_valid++;
            cfg_bits = {o_cfg_data, cfg_bits[7:1]};
        end
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Bypass stage delays the stream by one bit behind a captured zero
    function automatic logic [7:0] bypass_out(input logic [63:0] v);
        return {v[6:0], 1'b0};
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Status and pins change at a reference edge
    task automatic set_st(input logic pg, input logic cg, input logic cd);
        @(posedge i_ref_clk);
        i_power_good <= pg;
        i_configuring <= cg;
        i_configured <= cd;
        i_pins <= rnd();
        i_usercode <= rnd();
        i_la_tdo <= seed[3];
        din = {rnd(), rnd()};
    endtask

    task automatic load(input logic [9:0] op);
        jtap_ctrl_model_i.shift(1'b1, IR_LEN, {54'h0, op}, d);
        check(d[9:0], IR_CAPTURE);
    endtask

    task automatic dr(input int n);
        jtap_ctrl_model_i.shift(1'b0, n, din, d);
    endtask

    initial begin
        {i_nrst, i_power_good, i_configuring, i_configured, i_la_tdo} = '0;
        i_usercode = '0;
        i_pins = '0;
        repeat (5) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        jtap_ctrl_model_i.reset_tap(1'b0);
        check({o_pins.pad_oe, o_tdo_oe}, '0);
        set_st(1'b1, 1'b0, 1'b0);
        jtap_ctrl_model_i.reset_tap(1'b1);
        dr(32);
        check(d[31:0], {ID_VERSION, ID_PART, ID_MAKER, ID_LSB});
        // Unconfigured I/O-standard chain carries the PLL bits
        load(OP_CONFIG_IO);
        dr(48);
        check(d[47:32], din[15:0]);
        check({o_io_std, o_pll_cfg}, din[47:16]);
        pll_keep = din[31:16];
        set_st(1'b1, 1'b1, 1'b0);
        load(OP_CONFIG_IO);
        repeat (40) @(posedge i_ref_clk);
        check(n_abort, 1);
        // Scan tests run only outside configuration
        set_st(1'b1, 1'b0, 1'b1);
        load(OP_SAMPLE);
        check({o_pins.pad_out, o_pins.pad_oe}, {i_pins.core_out, i_pins.core_oe});
        check(o_pins.core_in, i_pins.pad_in);
        pat = din[15:8];
        din[23:16] = 8'hff;
        dr(BSR);
        check(d[7:0], i_pins.pad_in);
        load(OP_EXTEST);
        check({o_pins.pad_out, o_pins.pad_oe}, {pat, 8'hff});
        check(o_pins.core_in, din[7:0]);
        dr(BSR);
        check(d[7:0], i_pins.pad_in);
        ops = '{OP_CLAMP, OP_HIGHZ, OP_BYPASS, {2'b01, din[31:24]}};
        foreach (ops[k]) begin
            load(ops[k]);
            if (k == 0) check({o_pins.pad_out, o_pins.pad_oe}, {pat, 8'hff});
            if (k == 1) check(o_pins.pad_oe, 8'h00);
            din = {rnd(), rnd()};
            dr(8);
            check(d[7:0], bypass_out(din));
        end
        load(OP_USERCODE);
        dr(32);
        check(d[31:0], i_usercode);
        load(OP_LA_ACCESS);
        check(o_la_select, 1'b1);
        dr(8);
        check(d[7:0], {8{i_la_tdo}});
        load(OP_ICR_LOAD);
        dr(8);
        repeat (40) @(posedge i_ref_clk);
        check({n_valid, cfg_bits}, {32'h0000_0008, din[7:0]});
        load(OP_PULSE_RC);
        repeat (40) @(posedge i_ref_clk);
        check(n_pulse, 1);
        load(OP_CONFIG_IO);
        dr(48);
        check({d[31:16], n_abort}, {din[15:0], 32'h0000_0001});
        check({o_io_std, o_pll_cfg}, {din[47:32], pll_keep});
        tally_and_finish();
    end
endmodule
